//--- design/en_delay.sv
// delay line for the enable bit
// assumes input and output on the same clock
`timescale 1ns/1ps
`default_nettype none
module en_delay #(
   parameter int STAGES = 1
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   logic [STAGES-1:0] pipe_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pipe_r <= '0;
      end else begin
         pipe_r[0] <= d;
         for (int i = 1; i < STAGES; i++) begin
            pipe_r[i] <= pipe_r[i-1];
         end
      end
   end

   assign q = pipe_r[STAGES-1];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_delay_follow: assert property ($changed(d) |=> q == $past(d))
      else $error("enable delay line lost a change");
endmodule
`default_nettype wire

//--- design/i2c_ces_pkg.sv
// types shared by the enable/status/clear slice
// assumes nothing beyond the slice itself
package i2c_ces_pkg;
   typedef enum logic [2:0] {SEL_BUS_ACT, SEL_START, SEL_BCALL, SEL_ON_OFF,
                             SEL_STATE, SEL_NONE} reg_sel_t;
   typedef enum logic [1:0] {CTL_OFF, CTL_ON, CTL_DRAIN} ctl_state_t;
   typedef struct packed {
      logic initiator_fsm_busy;
      logic target_fsm_busy;
      logic bus_active;
      logic rx_in_progress;
      logic rx_queue_full;
      logic rx_queue_nonempty;
      logic tx_queue_empty;
      logic tx_queue_has_room;
      logic start_seen_evt;
      logic broadcast_call_evt;
   } unit_state_t;
   typedef struct packed {
      logic controller_active;
      logic fifo_flush;
      logic irq_keep;
      logic stop_after_xfer;
      logic nack_byte;
   } ctl_out_t;
endpackage

//--- design/i2c_ces_regs.svh
// register map and bit positions of the enable/status/clear slice
// assumes byte addresses on a 32-bit AXI4-Lite bus
`ifndef I2C_CES_REGS_SVH
`define I2C_CES_REGS_SVH
`define ADDR_BUS_ACT_CLR 32'h5000_1360
`define ADDR_START_CLR   32'h5000_1364
`define ADDR_BCALL_CLR   32'h5000_1368
`define ADDR_ON_OFF      32'h5000_136C
`define ADDR_STATE_FLAGS 32'h5000_1370
`define RAW_W            12
`define RAW_BUS_ACT      8
`define RAW_START        10
`define RAW_BCALL        11
`define EN_BIT           0
`define CLR_BIT          0
`define ST_ACTIVE        0
`define ST_TX_ROOM       1
`define ST_TX_EMPTY      2
`define ST_RX_NONEMPTY   3
`define ST_RX_FULL       4
`define ST_INIT_BUSY     5
`define ST_TGT_BUSY      6
`define ST_RESET         16'h0006
`define EN_LATENCY       2
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

//--- design/i2c_clear_enable_status.sv
// enable, status and read-to-clear flag slice of the two-wire controller
// assumes unit inputs come from logic on clk; register access over AXI4-Lite
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ces_regs.svh"

// Behaviour
// - reading start clear register clears start flag
// - reading broadcast clear register clears its flag
// - activity read-clear only when controller idle
// - hardware clears activity flag when disabled, quiet
// - activity clear register returns the activity flag
// - enable bit on/off, flushes FIFOs, resets 0
// - disabling flushes transmit and receive FIFOs
// - masked flags kept until controller reaches idle
// - disabled transmitter finishes transfer, then discards
// - disabled receiver ends after byte, no acknowledge
// - enable and disable take two clock cycles
// - status bit 6 shows target FSM busy
// - status bit 5 shows initiator FSM busy
// - status bit 4 shows receive queue full
// - status bit 3 shows receive queue nonempty
// - status bit 2 transmit empty, resets 1
// - status bit 1 transmit has room, resets 1
module i2c_clear_enable_status
   import i2c_ces_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire unit_state_t       unit_in,
   output logic [`RAW_W-1:0]      unmasked_irq_flags,
   output ctl_out_t               ctl_out
);

   // address decode shared by read and write paths
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a == ADDR_W'(`ADDR_BUS_ACT_CLR)) s = SEL_BUS_ACT;
      if (a == ADDR_W'(`ADDR_START_CLR))   s = SEL_START;
      if (a == ADDR_W'(`ADDR_BCALL_CLR))   s = SEL_BCALL;
      if (a == ADDR_W'(`ADDR_ON_OFF))      s = SEL_ON_OFF;
      if (a == ADDR_W'(`ADDR_STATE_FLAGS)) s = SEL_STATE;
      return s;
   endfunction

   // write channel
   logic [ADDR_W-1:0] awaddr_r;
   logic              aw_got_r;
   logic [31:0]       wdata_r;
   logic              wlane0_r;
   logic              w_got_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              wr_fire;
   reg_sel_t          wr_sel;

   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign wr_sel  = decode(awaddr_r);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awready_r <= 1'b1;
         aw_got_r  <= 1'b0;
         awaddr_r  <= '0;
      end else if (s_axi_awvalid && awready_r) begin
         awready_r <= 1'b0;
         aw_got_r  <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end else if (bvalid_r && s_axi_bready) begin
         awready_r <= 1'b1;
         aw_got_r  <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wready_r <= 1'b1;
         w_got_r  <= 1'b0;
         wdata_r  <= '0;
         wlane0_r <= 1'b0;
      end else if (s_axi_wvalid && wready_r) begin
         wready_r <= 1'b0;
         w_got_r  <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wlane0_r <= s_axi_wstrb[0];
      end else if (bvalid_r && s_axi_bready) begin
         wready_r <= 1'b1;
         w_got_r  <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // enable register and its delayed effect
   logic en_reg_r;
   logic en_eff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en_reg_r <= 1'b0;
      end else if (wr_fire && wr_sel == SEL_ON_OFF && wlane0_r) begin
         en_reg_r <= wdata_r[`EN_BIT];
      end
   end

   // one stage here plus the registered controls makes two cycles
   en_delay #(
      .STAGES (`EN_LATENCY - 1)
   ) u_en_delay (
      .clk  (clk),
      .rstn (rstn),
      .d    (en_reg_r),
      .q    (en_eff)
   );

   // read channel
   logic        arready_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        rd_fire;
   reg_sel_t    rd_sel;
   logic [15:0] rd_val;
   logic [15:0] status_r;
   logic        act_flag_r;
   logic        start_flag;
   logic        bcall_flag;

   assign rd_fire = s_axi_arvalid && arready_r;
   assign rd_sel  = decode(s_axi_araddr);

   always_comb begin
      rd_val = '0;
      unique case (rd_sel)
         SEL_BUS_ACT: rd_val[`CLR_BIT] = act_flag_r;
         SEL_START:   rd_val[`CLR_BIT] = start_flag;
         SEL_BCALL:   rd_val[`CLR_BIT] = bcall_flag;
         SEL_ON_OFF:  rd_val[`EN_BIT] = en_reg_r;
         SEL_STATE:   rd_val = status_r;
         SEL_NONE:    rd_val = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= `RESP_OKAY;
      end else if (rd_fire) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= {16'h0000, rd_val};
         rresp_r   <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rvalid_r && s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // read-to-clear flags
   logic busy_now;
   logic [1:0] evt_set;
   logic [1:0] evt_clr;
   logic [1:0] evt_flag;

   assign busy_now = unit_in.initiator_fsm_busy || unit_in.target_fsm_busy ||
                     unit_in.bus_active;
   assign evt_set  = {unit_in.broadcast_call_evt, unit_in.start_seen_evt};
   assign evt_clr  = {rd_fire && rd_sel == SEL_BCALL,
                      rd_fire && rd_sel == SEL_START};

   for (genvar g = 0; g < 2; g++) begin : g_evt
      rc_flag u_flag (
         .clk    (clk),
         .rstn   (rstn),
         .set    (evt_set[g]),
         .clr    (evt_clr[g]),
         .flag_r (evt_flag[g])
      );
   end

   assign start_flag = evt_flag[0];
   assign bcall_flag = evt_flag[1];

   // activity flag: held while anything is busy, so set wins over clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         act_flag_r <= 1'b0;
      end else if (busy_now) begin
         act_flag_r <= 1'b1;
      end else if (rd_fire && rd_sel == SEL_BUS_ACT) begin
         act_flag_r <= 1'b0;
      end else if (!en_eff) begin
         act_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unmasked_irq_flags <= '0;
      end else begin
         unmasked_irq_flags              <= '0;
         unmasked_irq_flags[`RAW_BUS_ACT] <= act_flag_r;
         unmasked_irq_flags[`RAW_START]   <= start_flag;
         unmasked_irq_flags[`RAW_BCALL]   <= bcall_flag;
      end
   end

   // status register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_r <= `ST_RESET;
      end else begin
         status_r                  <= '0;
         status_r[`ST_ACTIVE]      <= busy_now;
         status_r[`ST_TX_ROOM]     <= unit_in.tx_queue_has_room;
         status_r[`ST_TX_EMPTY]    <= unit_in.tx_queue_empty;
         status_r[`ST_RX_NONEMPTY] <= unit_in.rx_queue_nonempty;
         status_r[`ST_RX_FULL]     <= unit_in.rx_queue_full;
         status_r[`ST_INIT_BUSY]   <= unit_in.initiator_fsm_busy;
         status_r[`ST_TGT_BUSY]    <= unit_in.target_fsm_busy;
      end
   end

   // on/off sequencing
   ctl_state_t ctl_state_r;
   ctl_state_t ctl_state_nxt;
   logic       fsm_busy;

   assign fsm_busy = unit_in.initiator_fsm_busy || unit_in.target_fsm_busy;

   always_comb begin
      ctl_state_nxt = ctl_state_r;
      unique case (ctl_state_r)
         CTL_OFF:   if (en_eff) ctl_state_nxt = CTL_ON;
         CTL_ON:    if (!en_eff) ctl_state_nxt = fsm_busy ? CTL_DRAIN : CTL_OFF;
         CTL_DRAIN: begin
            if (en_eff) ctl_state_nxt = CTL_ON;
            else if (!fsm_busy) ctl_state_nxt = CTL_OFF;
         end
         default:   ctl_state_nxt = CTL_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_state_r <= CTL_OFF;
      end else begin
         ctl_state_r <= ctl_state_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_out <= '{controller_active: 1'b0, fifo_flush: 1'b1,
                      irq_keep: 1'b0, stop_after_xfer: 1'b0, nack_byte: 1'b0};
      end else begin
         ctl_out.controller_active <= (ctl_state_nxt == CTL_ON);
         ctl_out.fifo_flush        <= (ctl_state_nxt != CTL_ON);
         ctl_out.irq_keep          <= (ctl_state_nxt == CTL_DRAIN);
         ctl_out.stop_after_xfer   <= (ctl_state_nxt == CTL_DRAIN) &&
                                      !unit_in.rx_in_progress;
         ctl_out.nack_byte         <= (ctl_state_nxt == CTL_DRAIN) &&
                                      unit_in.rx_in_progress;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_act_stays_busy: assert property (busy_now |=> act_flag_r)
      else $error("activity flag dropped while busy");
   a_act_auto_clr: assert property (!busy_now && !en_eff && act_flag_r |=> !act_flag_r)
      else $error("activity flag not cleared when disabled and quiet");
   a_act_read_val: assert property (
      rd_fire && rd_sel == SEL_BUS_ACT |=> s_axi_rdata[0] == $past(act_flag_r))
      else $error("activity clear read returned wrong value");
   a_en_two_cycles: assert property (
      $rose(en_reg_r) ##1 en_reg_r |=> ctl_out.controller_active)
      else $error("enable did not act two cycles later");
   a_flush_on_off: assert property (
      $fell(en_reg_r) ##1 !en_reg_r |=> ctl_out.fifo_flush)
      else $error("FIFOs not flushed two cycles after disable");
   a_keep_till_idle: assert property (
      ctl_out.irq_keep && fsm_busy && !en_eff |=> ctl_out.irq_keep)
      else $error("flags released before idle");
   a_rx_nack_drain: assert property (
      ctl_state_r == CTL_DRAIN && !en_eff && fsm_busy && unit_in.rx_in_progress
      |=> ctl_out.nack_byte)
      else $error("receive not refused during shutdown");
   a_status_map: assert property (
      ##1 status_r[`ST_TGT_BUSY] == $past(unit_in.target_fsm_busy) &&
      status_r[`ST_INIT_BUSY] == $past(unit_in.initiator_fsm_busy) &&
      status_r[`ST_RX_FULL] == $past(unit_in.rx_queue_full))
      else $error("status bits do not follow the unit");
   a_resv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == '0)
      else $error("reserved bits read nonzero");

   c_act_clear: cover property (rd_fire && rd_sel == SEL_BUS_ACT && act_flag_r);
   c_drain: cover property (ctl_state_r == CTL_DRAIN ##1 ctl_state_r == CTL_OFF);
   c_enable: cover property (ctl_state_r == CTL_OFF ##1 ctl_state_r == CTL_ON);
   c_bad_addr: cover property (bvalid_r && bresp_r == `RESP_SLVERR);
endmodule
`default_nettype wire

//--- design/rc_flag.sv
// sticky interrupt flag set by hardware, cleared by a register read
// assumes set and clear are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module rc_flag (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag_r
);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= 1'b0;
      end else if (set) begin
         flag_r <= 1'b1;
      end else if (clr) begin
         flag_r <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_flag_set_wins: assert property (set |=> flag_r)
      else $error("flag set was lost");
   a_flag_read_clr: assert property (clr && !set |=> !flag_r)
      else $error("flag read did not clear");
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the enable/status/clear slice
// assumes the design files and unit_model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ces_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import i2c_ces_pkg::*;
   localparam unit_state_t IDLE = 10'h00C;
   logic        clk, rstn;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, r;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   unit_state_t unit_in, want, u;
   logic [11:0] unmasked_irq_flags;
   ctl_out_t    ctl_out;
   logic [33:0] rq[$], er;
   string       rn[$], en;
   logic [1:0]  bq[$];
   int          mismatches, total_checks, n;

   i2c_clear_enable_status u_i2c_clear_enable_status (.clk(clk), .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .unit_in(unit_in),
      .unmasked_irq_flags(unmasked_irq_flags), .ctl_out(ctl_out));
   unit_model u_unit_model (.clk(clk), .rstn(rstn), .ctl(ctl_out), .want(want),
      .unit_o(unit_in));

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   task automatic stop_test();
      if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] e);
      @(posedge clk);
      bq.push_back(e);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'h0;
   endtask

   task automatic rd(input logic [31:0] a, e, input logic [1:0] re);
      @(posedge clk);
      rq.push_back({re, e});
      rn.push_back($sformatf("read %h", a));
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'h0;
   endtask

   function automatic logic [31:0] st(input unit_state_t v);
      return {25'h0, v.target_fsm_busy, v.initiator_fsm_busy, v.rx_queue_full,
              v.rx_queue_nonempty, v.tx_queue_empty, v.tx_queue_has_room,
              v.initiator_fsm_busy | v.target_fsm_busy | v.bus_active};
   endfunction

   // result watcher: oldest note against each answer
   always @(posedge clk) begin
      if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
         er = rq.pop_front();
         en = rn.pop_front();
         `CHK(en, er, {s_axi_rresp, s_axi_rdata})
      end
      if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
         eb = bq.pop_front();
         `CHK("bresp", eb, s_axi_bresp)
      end
   end

   initial begin
      #200000;
      mismatches++;
      stop_test();
   end

   initial begin
      rstn = 1'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      want = IDLE;
      void'($urandom(17710));
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      @(posedge clk);
      #1 `CHK("flush", 1'h1, ctl_out.fifo_flush)
      rd(`ADDR_STATE_FLAGS, 32'h6, `RESP_OKAY);
      rd(`ADDR_ON_OFF, 32'h0, `RESP_OKAY);
      rd(`ADDR_BUS_ACT_CLR, 32'h0, `RESP_OKAY);
      rd(`ADDR_START_CLR, 32'h0, `RESP_OKAY);
      rd(`ADDR_BCALL_CLR, 32'h0, `RESP_OKAY);
      rd(32'h5000_1374, 32'h0, `RESP_SLVERR);
      wr(32'h5000_1374, 32'h1, 4'hF, `RESP_SLVERR);
      wr(`ADDR_STATE_FLAGS, 32'hFFFF, 4'hF, `RESP_OKAY);
      rd(`ADDR_STATE_FLAGS, 32'h6, `RESP_OKAY);
      wr(`ADDR_ON_OFF, $urandom | 32'h1, 4'hF, `RESP_OKAY);
      #1 `CHK("on early", 1'h0, ctl_out.controller_active)
      @(posedge clk);
      #1 `CHK("on", 1'h1, ctl_out.controller_active)
      `CHK("flush on", 1'h0, ctl_out.fifo_flush)
      wr(`ADDR_ON_OFF, 32'h0, 4'hE, `RESP_OKAY);
      rd(`ADDR_ON_OFF, 32'h1, `RESP_OKAY);
      repeat (4) begin
         r = $urandom;
         u = unit_state_t'({r[9:8], 1'h1, r[6:2], 2'h0});
         want <= u;
         repeat (3) @(posedge clk);
         rd(`ADDR_STATE_FLAGS, st(u), `RESP_OKAY);
      end
      want <= IDLE;
      repeat (3) @(posedge clk);
      rd(`ADDR_BUS_ACT_CLR, 32'h1, `RESP_OKAY);
      rd(`ADDR_BUS_ACT_CLR, 32'h0, `RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
         want <= k ? 10'h00D : 10'h00E;
         @(posedge clk);
         want <= IDLE;
         repeat (3) @(posedge clk);
         #1 `CHK("evt", 12'h001 << (k ? `RAW_BCALL : `RAW_START), unmasked_irq_flags)
         rd(k ? `ADDR_BCALL_CLR : `ADDR_START_CLR, 32'h1, `RESP_OKAY);
         rd(k ? `ADDR_BCALL_CLR : `ADDR_START_CLR, 32'h0, `RESP_OKAY);
         @(posedge clk);
         #1 `CHK("evt clr", 12'h000, unmasked_irq_flags)
         @(posedge clk);
      end
      for (int k = 0; k < 2; k++) begin
         want <= k ? 10'h254 : 10'h214;
         repeat (3) @(posedge clk);
         rd(`ADDR_BUS_ACT_CLR, 32'h1, `RESP_OKAY);
         rd(`ADDR_BUS_ACT_CLR, 32'h1, `RESP_OKAY);
         wr(`ADDR_ON_OFF, 32'h0, 4'hF, `RESP_OKAY);
         @(posedge clk);
         #1 `CHK("keep", 1'h1, ctl_out.irq_keep)
         `CHK("flush off", 1'h1, ctl_out.fifo_flush)
         `CHK("stop", k == 0, ctl_out.stop_after_xfer)
         `CHK("nack", k == 1, ctl_out.nack_byte)
         `CHK("act kept", 1'h1, unmasked_irq_flags[`RAW_BUS_ACT])
         n = 0;
         while (ctl_out.irq_keep !== 1'h0 && n < 60) begin
            @(posedge clk);
            n++;
         end
         #1 `CHK("drain done", 1'h0, ctl_out.irq_keep)
         repeat (3) @(posedge clk);
         #1 `CHK("act auto", 1'h0, unmasked_irq_flags[`RAW_BUS_ACT])
         `CHK("off", 1'h0, ctl_out.controller_active)
         rd(`ADDR_STATE_FLAGS, 32'h6, `RESP_OKAY);
         want <= IDLE;
         wr(`ADDR_ON_OFF, 32'h1, 4'h1, `RESP_OKAY);
      end
      wr(`ADDR_ON_OFF, 32'h0, 4'hF, `RESP_OKAY);
      #1 `CHK("off early", 1'h1, ctl_out.controller_active)
      @(posedge clk);
      #1 `CHK("off late", 1'h0, ctl_out.controller_active)
      `CHK("flush idle", 1'h1, ctl_out.fifo_flush)
      stop_test();
   end
endmodule
`default_nettype wire

//--- test/unit_model.sv
// behavioural model of the controller core behind the slice
// assumes want is driven by the bench on clk; mirrors it one cycle late
`timescale 1ns/1ps
`default_nettype none
module unit_model
   import i2c_ces_pkg::*;
#(
   parameter int DRAIN_CYC = 6
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire ctl_out_t    ctl,
   input  wire unit_state_t want,
   output unit_state_t      unit_o
);
   logic [3:0] cnt_r;
   logic       done_r;

   // a stopped transfer ends some cycles later, then the fsm goes idle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r  <= 4'h0;
         done_r <= 1'h0;
      end else if (!(want.initiator_fsm_busy | want.target_fsm_busy)) begin
         cnt_r  <= 4'h0;
         done_r <= 1'h0;
      end else if (ctl.stop_after_xfer | ctl.nack_byte) begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == DRAIN_CYC) begin
            done_r <= 1'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unit_o <= 10'h00C;
      end else begin
         unit_o <= want;
         if (done_r) begin
            unit_o.initiator_fsm_busy <= 1'h0;
            unit_o.target_fsm_busy    <= 1'h0;
            unit_o.bus_active         <= 1'h0;
            unit_o.rx_in_progress     <= 1'h0;
         end
         // flush leaves both queues empty
         if (ctl.fifo_flush) begin
            unit_o.rx_queue_full     <= 1'h0;
            unit_o.rx_queue_nonempty <= 1'h0;
            unit_o.tx_queue_empty    <= 1'h1;
            unit_o.tx_queue_has_room <= 1'h1;
         end
      end
   end
endmodule
`default_nettype wire
